/* File: ubg_baud_gen.sv */
// fractional bit period generator
`timescale 1ns/10ps
module ubg_baud_gen #(
  parameter int DW = 19,
  parameter int MW = 16
) (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          run,
  input  wire logic          restart,
  input  wire logic [DW-1:0] divisor,
  input  wire logic [MW-1:0] mask,
  output logic               tick,
  output logic               mid
);
  logic [DW:0]   cnt_r;
  logic [3:0]    slot_r;
  logic [DW:0]   eff_div;
  logic [DW:0]   period;
  logic [DW:0]   last;
  logic [DW:0]   gap_r;

  // ----------------------------------------
  // period of the current slot
  // ----------------------------------------
  assign eff_div = (divisor == '0) ? (DW+1)'(1) : {1'b0, divisor};
  assign period  = eff_div + (DW+1)'(mask[slot_r]);  // see RULE15
  assign last    = period - (DW+1)'(1);
  assign tick    = run && !restart && (cnt_r == last);
  assign mid     = run && !restart && (cnt_r == (last >> 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= '0;
      slot_r <= 4'h0;
    end else if (!run || restart) begin
      cnt_r  <= '0;
      slot_r <= 4'h0;
    end else if (tick) begin
      cnt_r  <= '0;
      slot_r <= slot_r + 4'h1;  // see RULE5
    end else begin
      cnt_r  <= cnt_r + (DW+1)'(1);  // see RULE6
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= (DW+1)'(1);
    end else if (!run || restart || tick) begin
      gap_r <= (DW+1)'(1);
    end else begin
      gap_r <= gap_r + (DW+1)'(1);
    end
  end

  property p_slot_period;
    @(posedge mclk) disable iff (!arst_n)
    tick |-> (gap_r == period);
  endproperty
  a_slot_period: assert property (p_slot_period) else $error("bit period wrong"); // see RULE15

  property p_count_every_cycle;
    @(posedge mclk) disable iff (!arst_n)
    (run && !restart && !tick) |=> (cnt_r == $past(cnt_r) + (DW+1)'(1)) || !run || restart;
  endproperty
  a_count_every_cycle: assert property (p_count_every_cycle) else $error("count skipped"); // see RULE6

  property p_slot_advance;
    @(posedge mclk) disable iff (!arst_n)
    (tick && run) |=> (slot_r == $past(slot_r) + 4'h1) || !run || restart;
  endproperty
  a_slot_advance: assert property (p_slot_advance) else $error("slot not advanced"); // see RULE5
endmodule

/* File: ubg_channel_top.sv */
// uart channel with direction enables and fractional baud generation
`timescale 1ns/10ps
// Functional notes
// RULE1: enable bit 0 lets the transmitter run; zero disables it.
// RULE2: enable bit 1 lets the receiver run; zero disables it.
// RULE3: software writes zero into unused upper enable and divisor bits.
// RULE4: software enables tx queue, then both directions, then both queues.
// RULE5: 19-bit divisor with separate 16-bit tx and rx fraction patterns.
// RULE6: bit timing is counted on the internal reference clock only.
// RULE7: software sets divisor to truncated 48000000 over baud rate.
// RULE8: divisor bytes give bits 7:0, 15:8 and 18:16.
// RULE9: software forms pattern index from fractional quotient times 32.
// RULE10: unlisted rates take tx pattern from the per-index table.
// RULE11: receive pattern uses the same index as transmit.
// RULE12: receive pattern column chosen by divisor parity.
// RULE13: listed rates use their tabulated divisor and pattern pairs.
// RULE14: queue enable bit 0 is transmit, bit 1 is receive.
// RULE15: bit period is divisor plus one when the slot's pattern bit is set.
// RULE16: disabled transmitter holds line idle; disabled receiver samples nothing.
module ubg_channel_top (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       reg_sel_mgr,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            txd,
  input  wire logic       rxd,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_frame_err
);
  logic [1:0]                    enable_r;
  logic [1:0]                    queue_r;
  logic [ubg_pkg::DIV_WIDTH-1:0]  div_r;
  logic [ubg_pkg::MASK_WIDTH-1:0] txm_r;
  logic [ubg_pkg::MASK_WIDTH-1:0] rxm_r;
  logic [7:0]                    rdata_nxt;
  logic                          wr_u;
  logic                          wr_m;
  logic                          tx_on;
  logic                          rx_on;
  logic                          tx_accept;
  logic                          tx_tick;
  logic                          rx_mid;
  logic                          rx_start;
  logic                          rxd_d_r;
  ubg_pkg::ubg_tx_state_t        tx_st_r;
  ubg_pkg::ubg_rx_state_t        rx_st_r;
  logic [9:0]                    tx_sh_r;
  logic [3:0]                    tx_cnt_r;
  logic [3:0]                    rx_cnt_r;
  logic [7:0]                    rx_sh_r;
  logic                          txd_r;
  logic [7:0]                    rx_data_r;
  logic                          rx_valid_r;
  logic                          rx_ferr_r;

  // ----------------------------------------
  // register access
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign wr_u = reg_wr && !reg_sel_mgr;
  assign wr_m = reg_wr && reg_sel_mgr;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enable_r <= ubg_pkg::RST_ENABLE;
      queue_r  <= ubg_pkg::RST_QUEUE;
      div_r    <= ubg_pkg::RST_DIV;
      txm_r    <= ubg_pkg::RST_MASK;
      rxm_r    <= ubg_pkg::RST_MASK;
    end else begin
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_CHANNEL_DIRECTION_ENABLE)) begin
        enable_r <= reg_wdata[1:0];
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_BAUD_DIVISOR_LOW)) begin
        div_r[7:0] <= reg_wdata;  // see RULE8
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_BAUD_DIVISOR_MID)) begin
        div_r[15:8] <= reg_wdata;  // see RULE8
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_BAUD_DIVISOR_HIGH)) begin
        div_r[18:16] <= reg_wdata[ubg_pkg::DIV_HIGH_BITS-1:0];  // see RULE8
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_TRANSMIT_FRACTION_PATTERN_LOW)) begin
        txm_r[7:0] <= reg_wdata;
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_TRANSMIT_FRACTION_PATTERN_HIGH)) begin
        txm_r[15:8] <= reg_wdata;
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_RECEIVE_FRACTION_PATTERN_LOW)) begin
        rxm_r[7:0] <= reg_wdata;
      end
      if (wr_u && hit(reg_addr, ubg_pkg::OFF_RECEIVE_FRACTION_PATTERN_HIGH)) begin
        rxm_r[15:8] <= reg_wdata;
      end
      if (wr_m && hit(reg_addr, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE)) begin
        queue_r <= reg_wdata[1:0];  // see RULE14
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_sel_mgr) begin
      if (hit(reg_addr, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE)) rdata_nxt = {6'h00, queue_r};
    end else begin
      case (reg_addr)
        ubg_pkg::OFF_CHANNEL_DIRECTION_ENABLE:       rdata_nxt = {6'h00, enable_r};
        ubg_pkg::OFF_BAUD_DIVISOR_LOW:               rdata_nxt = div_r[7:0];
        ubg_pkg::OFF_BAUD_DIVISOR_MID:               rdata_nxt = div_r[15:8];
        ubg_pkg::OFF_BAUD_DIVISOR_HIGH:              rdata_nxt = {5'h00, div_r[18:16]};
        ubg_pkg::OFF_TRANSMIT_FRACTION_PATTERN_LOW:  rdata_nxt = txm_r[7:0];
        ubg_pkg::OFF_TRANSMIT_FRACTION_PATTERN_HIGH: rdata_nxt = txm_r[15:8];
        ubg_pkg::OFF_RECEIVE_FRACTION_PATTERN_LOW:   rdata_nxt = rxm_r[7:0];
        ubg_pkg::OFF_RECEIVE_FRACTION_PATTERN_HIGH:  rdata_nxt = rxm_r[15:8];
        default:                                     rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  assign tx_on     = enable_r[ubg_pkg::BIT_TX_ENABLE] && queue_r[ubg_pkg::BIT_TX_QUEUE];  // see RULE1
  assign tx_ready  = tx_on && (tx_st_r == ubg_pkg::TX_IDLE);  // see RULE14
  assign tx_accept = tx_valid && tx_ready;
  assign txd       = txd_r;

  ubg_baud_gen #(.DW(ubg_pkg::DIV_WIDTH), .MW(ubg_pkg::MASK_WIDTH)) u_tx_gen (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .run     (tx_on && (tx_st_r == ubg_pkg::TX_SEND)),
    .restart (tx_accept),
    .divisor (div_r),
    .mask    (txm_r),
    .tick    (tx_tick),
    .mid     ()
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_r  <= ubg_pkg::TX_IDLE;
      tx_sh_r  <= 10'h3ff;
      tx_cnt_r <= 4'h0;
      txd_r    <= 1'b1;
    end else if (!tx_on) begin
      tx_st_r  <= ubg_pkg::TX_IDLE;  // see RULE16
      tx_sh_r  <= 10'h3ff;
      tx_cnt_r <= 4'h0;
      txd_r    <= 1'b1;
    end else begin
      case (tx_st_r)
        ubg_pkg::TX_IDLE: begin
          txd_r <= 1'b1;
          if (tx_accept) begin
            tx_sh_r  <= {1'b1, tx_data, 1'b0};
            tx_cnt_r <= 4'h0;
            txd_r    <= 1'b0;
            tx_st_r  <= ubg_pkg::TX_SEND;
          end
        end
        ubg_pkg::TX_SEND: begin
          txd_r <= tx_sh_r[0];
          if (tx_tick) begin
            tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
            tx_cnt_r <= tx_cnt_r + 4'h1;
            txd_r    <= tx_sh_r[1];
            if (tx_cnt_r == ubg_pkg::LAST_BIT) begin
              tx_st_r <= ubg_pkg::TX_IDLE;
              txd_r   <= 1'b1;
            end
          end
        end
        default: tx_st_r <= ubg_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_on    = enable_r[ubg_pkg::BIT_RX_ENABLE] && queue_r[ubg_pkg::BIT_RX_QUEUE];  // see RULE2
  assign rx_start = rx_on && (rx_st_r == ubg_pkg::RX_IDLE) && rxd_d_r && !rxd;
  assign rx_data      = rx_data_r;
  assign rx_valid     = rx_valid_r;
  assign rx_frame_err = rx_ferr_r;

  ubg_baud_gen #(.DW(ubg_pkg::DIV_WIDTH), .MW(ubg_pkg::MASK_WIDTH)) u_rx_gen (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .run     (rx_on && (rx_st_r == ubg_pkg::RX_RECV)),
    .restart (rx_start),
    .divisor (div_r),
    .mask    (rxm_r),
    .tick    (),
    .mid     (rx_mid)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_d_r    <= 1'b1;
      rx_st_r    <= ubg_pkg::RX_IDLE;
      rx_cnt_r   <= 4'h0;
      rx_sh_r    <= 8'h00;
      rx_data_r  <= 8'h00;
      rx_valid_r <= 1'b0;
      rx_ferr_r  <= 1'b0;
    end else begin
      rxd_d_r    <= rxd;
      rx_valid_r <= 1'b0;
      rx_ferr_r  <= 1'b0;
      if (!rx_on) begin
        rx_st_r  <= ubg_pkg::RX_IDLE;  // see RULE16
        rx_cnt_r <= 4'h0;
      end else begin
        case (rx_st_r)
          ubg_pkg::RX_IDLE: begin
            rx_cnt_r <= 4'h0;
            if (rx_start) rx_st_r <= ubg_pkg::RX_RECV;
          end
          ubg_pkg::RX_RECV: begin
            if (rx_mid) begin
              rx_cnt_r <= rx_cnt_r + 4'h1;
              if (rx_cnt_r == 4'h0 && rxd) begin
                rx_st_r <= ubg_pkg::RX_IDLE;
              end else if (rx_cnt_r == ubg_pkg::LAST_BIT) begin
                rx_st_r    <= ubg_pkg::RX_IDLE;
                rx_data_r  <= rx_sh_r;
                rx_valid_r <= 1'b1;
                rx_ferr_r  <= !rxd;
              end else if (rx_cnt_r != 4'h0) begin
                rx_sh_r <= {rxd, rx_sh_r[7:1]};
              end
            end
          end
          default: rx_st_r <= ubg_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_tx_idle_when_off;
    @(posedge mclk) disable iff (!arst_n)
    !enable_r[ubg_pkg::BIT_TX_ENABLE] |=> txd;
  endproperty
  a_tx_idle_when_off: assert property (p_tx_idle_when_off) else $error("line not idle"); // see RULE16

  property p_tx_start_bit;
    @(posedge mclk) disable iff (!arst_n)
    tx_accept |=> !txd && (tx_st_r == ubg_pkg::TX_SEND);
  endproperty
  a_tx_start_bit: assert property (p_tx_start_bit) else $error("no start bit"); // see RULE1

  property p_ready_needs_enables;
    @(posedge mclk) disable iff (!arst_n)
    tx_ready |-> txd && enable_r[ubg_pkg::BIT_TX_ENABLE] && queue_r[ubg_pkg::BIT_TX_QUEUE];
  endproperty
  a_ready_needs_enables: assert property (p_ready_needs_enables) else $error("ready while off"); // see RULE14

  property p_rx_off_idle;
    @(posedge mclk) disable iff (!arst_n)
    !enable_r[ubg_pkg::BIT_RX_ENABLE] |=> (rx_st_r == ubg_pkg::RX_IDLE) && !rx_valid;
  endproperty
  a_rx_off_idle: assert property (p_rx_off_idle) else $error("receiver active while off"); // see RULE2

  sequence s_rx_edge;
    rx_on && (rx_st_r == ubg_pkg::RX_IDLE) && $fell(rxd);
  endsequence
  sequence s_rx_busy;
    rx_st_r == ubg_pkg::RX_RECV;
  endsequence
  property p_rx_start;
    @(posedge mclk) disable iff (!arst_n)
    s_rx_edge |=> s_rx_busy or !rx_on;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("start edge missed"); // see RULE16

  property p_div_high_write;
    @(posedge mclk) disable iff (!arst_n)
    (wr_u && reg_addr == ubg_pkg::OFF_BAUD_DIVISOR_HIGH)
      |=> div_r[18:16] == $past(reg_wdata[2:0]);
  endproperty
  a_div_high_write: assert property (p_div_high_write) else $error("divisor top not stored"); // see RULE8

  property p_div_read_back;
    @(posedge mclk) disable iff (!arst_n)
    (reg_rd && !reg_sel_mgr && reg_addr == ubg_pkg::OFF_BAUD_DIVISOR_HIGH)
      |=> reg_rvalid && reg_rdata == {5'h00, $past(div_r[18:16])};
  endproperty
  a_div_read_back: assert property (p_div_read_back) else $error("divisor read wrong"); // see RULE8
endmodule

/* File: ubg_channel_top_tb.sv */
// self-checking bench for the channel enable and fractional baud block
`timescale 1ns/10ps
module ubg_channel_top_tb;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_sel_mgr = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_valid = 1'b0;
  logic        rxd = 1'b1;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        tx_ready;
  logic        txd;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_frame_err;
  int          errors = 0;
  int          tests_run = 0;
  logic [7:0]  rd_q[$];
  logic [8:0]  rx_q[$];
  // listed rates first, last entry computed from an unlisted rate
  logic [18:0] cf_div[4] = '{19'h00004, 19'h00007, 19'h0000f, 19'h00000};
  logic [15:0] cf_tm[4]  = '{16'h0000, 16'h0b6d, 16'h0492, 16'h0000};
  logic [15:0] cf_rm[4]  = '{16'h0000, 16'h0db6, 16'h0492, 16'h0000};
  localparam int BAUD_X = 184473;
  int          c_idx;

  always #20 mclk = ~mclk;

  ubg_channel_top dut (
    .mclk(mclk), .arst_n(arst_n), .reg_sel_mgr(reg_sel_mgr), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .txd(txd), .rxd(rxd), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_frame_err(rx_frame_err)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task tick;
    @(posedge mclk);
    #1;
  endtask

  task wr(logic mgr, logic [7:0] a, logic [7:0] d);
    reg_sel_mgr = mgr;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask

  task rd(logic mgr, logic [7:0] a, logic [7:0] exp);
    rd_q.push_back(exp);
    reg_sel_mgr = mgr;
    reg_addr = a;
    reg_rd = 1'b1;
    tick;
    reg_rd = 1'b0;
    tick;
  endtask

  function automatic int per(logic [18:0] d, logic [15:0] m, int k);
    return ((d == 19'h0) ? 1 : int'(d)) + int'(m[k]);
  endfunction

  // pattern pair {tx, rx} by index and divisor parity, rows 6 and 31 only
  function automatic logic [31:0] pat(int idx, logic odd);
    case (idx)
      6:       return odd ? 32'h0104_0108 : 32'h0104_0820;
      31:      return odd ? 32'h0fff_0ffd : 32'h0fff_0ffe;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // transmit one byte and sample each bit in its middle
  task send(logic [7:0] b, logic [18:0] d, logic [15:0] m);
    int n;
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    tx_data = b;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    check("tx_ready", tx_ready, 1'b1);
    if (tx_ready !== 1'b1) stop_test;
    tick;
    tx_valid = 1'b0;
    n = 0;
    while (txd !== 1'b0 && n < 3) begin
      tick;
      n++;
    end
    if (txd !== 1'b0) begin
      check("tx start bit", txd, 1'b0);
      stop_test;
    end
    for (int k = 0; k < 10; k++) begin
      repeat (per(d, m, k) / 2) tick;
      check("txd bit", txd, fr[k]);
      repeat (per(d, m, k) - per(d, m, k) / 2) tick;
    end
  endtask

  // drive one frame into rxd with the receive pattern timing
  task drive_rx(logic [7:0] b, logic [18:0] d, logic [15:0] m, logic stp, logic expect_it);
    logic [9:0] fr;
    fr = {stp, b, 1'b0};
    if (expect_it) rx_q.push_back({~stp, b});
    for (int k = 0; k < 10; k++) begin
      rxd = fr[k];
      repeat (per(d, m, k)) tick;
    end
    rxd = 1'b1;
    repeat (4) tick;
  endtask

  task done(string name);
    $display("test %0s done", name);
  endtask

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      if (rd_q.size() == 0) check("spare reg_rvalid", 1'b1, 1'b0);
      else check("reg_rdata", reg_rdata, rd_q.pop_front());
    end
    if (rx_valid === 1'b1) begin
      if (rx_q.size() == 0) check("spare rx_valid", 1'b1, 1'b0);
      else check("rx frame", {rx_frame_err, rx_data}, rx_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge mclk);
    check("watchdog", 1'b1, 1'b0);
    stop_test;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hfeb0));
    tick;
    check("txd in reset", txd, 1'b1);
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    for (int a = 3; a <= 10; a++) rd(1'b0, 8'(a), 8'h00);
    rd(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'h00);
    done("reset values");
    for (int a = 3; a <= 10; a++) begin
      wr(1'b0, 8'(a), (a == 3) ? 8'h03 : (a == 6) ? 8'h07 : 8'hff);
      rd(1'b0, 8'(a), (a == 3) ? 8'h03 : (a == 6) ? 8'h07 : 8'hff);
      wr(1'b0, 8'(a), 8'h00);
    end
    wr(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'hff);
    rd(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'h03);
    wr(1'b0, 8'h0b, 8'h5a);
    rd(1'b0, 8'h0b, 8'h00);
    rd(1'b0, 8'h02, 8'h00);
    done("register access");
    wr(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'h01);
    tx_valid = 1'b1;
    repeat (5) begin
      tick;
      check("tx_ready disabled", tx_ready, 1'b0);
      check("txd idle", txd, 1'b1);
    end
    tx_valid = 1'b0;
    wr(1'b0, ubg_pkg::OFF_CHANNEL_DIRECTION_ENABLE, 8'h03);
    wr(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'h03);
    done("enable order");
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        cf_div[3] = 19'(ubg_pkg::REF_CLK_HZ / BAUD_X);
        c_idx = ((ubg_pkg::REF_CLK_HZ % BAUD_X) * 32) / BAUD_X;
        {cf_tm[3], cf_rm[3]} = pat(c_idx, cf_div[3][0]);
      end
      wr(1'b0, ubg_pkg::OFF_BAUD_DIVISOR_LOW, cf_div[i][7:0]);
      wr(1'b0, ubg_pkg::OFF_BAUD_DIVISOR_MID, cf_div[i][15:8]);
      wr(1'b0, ubg_pkg::OFF_BAUD_DIVISOR_HIGH, {5'h00, cf_div[i][18:16]});
      wr(1'b0, ubg_pkg::OFF_TRANSMIT_FRACTION_PATTERN_LOW, cf_tm[i][7:0]);
      wr(1'b0, ubg_pkg::OFF_TRANSMIT_FRACTION_PATTERN_HIGH, cf_tm[i][15:8]);
      wr(1'b0, ubg_pkg::OFF_RECEIVE_FRACTION_PATTERN_LOW, cf_rm[i][7:0]);
      wr(1'b0, ubg_pkg::OFF_RECEIVE_FRACTION_PATTERN_HIGH, cf_rm[i][15:8]);
      send(8'($urandom), cf_div[i], cf_tm[i]);
      drive_rx(8'($urandom), cf_div[i], cf_rm[i], 1'b1, 1'b1);
    end
    drive_rx(8'($urandom), cf_div[3], cf_rm[3], 1'b0, 1'b1);
    done("baud timing");
    tx_data = 8'h00;
    tx_valid = 1'b1;
    tick;
    tx_valid = 1'b0;
    repeat (20) tick;
    wr(1'b0, ubg_pkg::OFF_CHANNEL_DIRECTION_ENABLE, 8'h02);
    check("txd after abort", txd, 1'b1);
    check("tx_ready after abort", tx_ready, 1'b0);
    wr(1'b0, ubg_pkg::OFF_CHANNEL_DIRECTION_ENABLE, 8'h01);
    drive_rx(8'($urandom), cf_div[3], cf_rm[3], 1'b1, 1'b0);
    wr(1'b0, ubg_pkg::OFF_CHANNEL_DIRECTION_ENABLE, 8'h03);
    drive_rx(8'($urandom), cf_div[3], cf_rm[3], 1'b1, 1'b1);
    wr(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'h02);
    check("tx_ready queue off", tx_ready, 1'b0);
    wr(1'b1, ubg_pkg::OFF_CHANNEL_QUEUE_ENABLE, 8'h03);
    check("tx_ready queue on", tx_ready, 1'b1);
    done("disable and abort");
    repeat (5) tick;
    check("pending reads", 16'(rd_q.size()), 16'h0000);
    check("pending frames", 16'(rx_q.size()), 16'h0000);
    stop_test;
  end
endmodule

/* File: ubg_pkg.sv */
// constants for the channel enable and fractional baud block
package ubg_pkg;
  // ----------------------------------------
  // register offsets, uart block
  // ----------------------------------------
  localparam logic [7:0] OFF_CHANNEL_DIRECTION_ENABLE      = 8'h03;
  localparam logic [7:0] OFF_BAUD_DIVISOR_LOW              = 8'h04;
  localparam logic [7:0] OFF_BAUD_DIVISOR_MID              = 8'h05;
  localparam logic [7:0] OFF_BAUD_DIVISOR_HIGH             = 8'h06;
  localparam logic [7:0] OFF_TRANSMIT_FRACTION_PATTERN_LOW = 8'h07;
  localparam logic [7:0] OFF_TRANSMIT_FRACTION_PATTERN_HIGH = 8'h08;
  localparam logic [7:0] OFF_RECEIVE_FRACTION_PATTERN_LOW  = 8'h09;
  localparam logic [7:0] OFF_RECEIVE_FRACTION_PATTERN_HIGH = 8'h0a;
  // ----------------------------------------
  // register offsets, manager block
  // ----------------------------------------
  localparam logic [7:0] OFF_CHANNEL_QUEUE_ENABLE          = 8'h10;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_TX_ENABLE   = 0;
  localparam int BIT_RX_ENABLE   = 1;
  localparam int BIT_TX_QUEUE    = 0;
  localparam int BIT_RX_QUEUE    = 1;
  localparam int DIV_WIDTH       = 19;
  localparam int MASK_WIDTH      = 16;
  localparam int DIV_HIGH_BITS   = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0]  RST_ENABLE = 2'h0;
  localparam logic [1:0]  RST_QUEUE  = 2'h0;
  localparam logic [18:0] RST_DIV    = 19'h00000;
  localparam logic [15:0] RST_MASK   = 16'h0000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int REF_CLK_HZ   = 48000000;
  localparam int FRAME_BITS   = 10;
  localparam logic [3:0] LAST_BIT = 4'h9;
  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} ubg_tx_state_t;
  typedef enum logic {RX_IDLE = 1'b0, RX_RECV = 1'b1} ubg_rx_state_t;
endpackage
